// *** inc/awu_pkg.sv ***
// package for the timed wakeup from halt unit: register map, field layout,
// reset values, states and cycle counts.
// assumes a 100 MHz mclk and 32-bit apb with one register per word.
`default_nettype none
package awu_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // printed offsets are register indices, byte address is four times them
   localparam logic [7:0] CSR_INDEX = 8'h2e;
   localparam logic [7:0] PRE_INDEX = 8'h2f;
   localparam logic [7:0] IST_INDEX = 8'h30;
   localparam logic [7:0] IMK_INDEX = 8'h31;
   localparam logic [9:0] CSR_ADDR = {CSR_INDEX, 2'b00};
   localparam logic [9:0] PRE_ADDR = {PRE_INDEX, 2'b00};
   localparam logic [9:0] IST_ADDR = {IST_INDEX, 2'b00};
   localparam logic [9:0] IMK_ADDR = {IMK_INDEX, 2'b00};
   // control/status field positions
   localparam int unsigned FLAG_BIT = 2;
   localparam int unsigned MEAS_BIT = 1;
   localparam int unsigned EN_BIT = 0;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] PRE_RESET = 8'hff;
   localparam logic [7:0] PRE_FORBIDDEN = 8'h00;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // interrupt status bits
   localparam int unsigned EV_TIMED = 0;
   localparam int unsigned EV_OTHER = 1;
   localparam logic [1:0] CC_HALT_MASK = 2'h2;
   localparam int unsigned FIXED_DIV = 64;
   localparam int unsigned STAB_SHORT = 256;
   localparam int unsigned STAB_LONG = 4096;
   localparam int unsigned RC_STARTUP_NS = 20000;
   localparam int unsigned RC_STARTUP_CYC =
      (RC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 13;

   typedef struct packed {
      logic flag;
      logic measure;
      logic enable;
   } awu_csr_t;

   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [9:0] addr;
      logic [31:0] wdata;
   } awu_apb_req_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_RC_START = 3'b001,
      ST_COUNT = 3'b010,
      ST_HALT = 3'b011,
      ST_ACT_HALT = 3'b100,
      ST_STAB = 3'b101
   } awu_state_t;
endpackage
`default_nettype wire

// *** hw/awu_prescaler.sv ***
// fixed divide-by-64 followed by the programmable prescaler.
// assumes tick is a one-cycle pulse per rc rising edge on mclk.
`default_nettype none
module awu_prescaler #(
   parameter int unsigned DIV = awu_pkg::FIXED_DIV
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // control
   input wire logic run,
   input wire logic tick,
   input wire logic [7:0] factor,
   // result
   output logic done
);
   localparam int unsigned DW = $clog2(DIV);
   localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

   logic [DW-1:0] div_cnt;
   logic [7:0] pre_cnt;
   wire div_wrap = tick && (div_cnt == DIV_LAST);
   wire pre_last = (pre_cnt + 8'h01) == factor;

   // counters restart whenever run drops, so each halt starts from zero
   always_ff @(posedge mclk)
   begin
      if (srst || !run)
      begin
         div_cnt <= '0;
         pre_cnt <= 8'h00;
         done <= 1'b0;
      end
      else
      begin
         done <= div_wrap && pre_last;
         if (tick)
            div_cnt <= div_wrap ? '0 : div_cnt + DW'(1);
         if (div_wrap)
            pre_cnt <= pre_last ? 8'h00 : pre_cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

// *** hw/awu_top.sv ***
// timed wakeup from halt unit: halt mode sequencing, rc prescaler, apb
// registers and interrupt. assumes the cpu pulses halt_exec for the halt
// instruction and stalls while core_clk_enable is low.
`default_nettype none
module awu_top (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu and clock controller
   input wire logic halt_exec,
   input wire logic osc_irq_enable,
   input wire logic halt_exit_irq,
   input wire logic watchdog_running,
   input wire logic watchdog_halt_option,
   input wire logic long_stab_strap,
   output logic cc_force,
   output logic [1:0] cc_force_value,
   output logic core_clk_enable,
   output logic main_osc_enable,
   output logic active_halt,
   output logic watchdog_reset,
   output logic timed_wake_irq,
   // wakeup rc oscillator
   input wire logic wake_rc_pin,
   output logic rc_osc_enable,
   output logic timer_capture_input_two,
   // summary interrupt
   output logic irq
);
   awu_pkg::awu_state_t state, next_state;
   awu_pkg::awu_csr_t csr;
   awu_pkg::awu_apb_req_t req;
   logic [7:0] wake_prescaler_reg;
   logic [1:0] irq_status, irq_mask;
   logic [awu_pkg::CNT_W-1:0] cnt;
   logic rc_s1, rc_s2, rc_s3, rc_lvl, rc_prev;
   logic long_stab, strap_taken;
   logic pre_done;

   ////////////////////////////////////////////////////////////////////////
   // apb decode

   assign req = '{psel, penable, pwrite, paddr, pwdata};
   wire hit_csr = req.addr == awu_pkg::CSR_ADDR;
   wire hit_pre = req.addr == awu_pkg::PRE_ADDR;
   wire hit_ist = req.addr == awu_pkg::IST_ADDR;
   wire hit_imk = req.addr == awu_pkg::IMK_ADDR;
   wire mapped = hit_csr || hit_pre || hit_ist || hit_imk;
   wire setup = req.sel && !req.enable;
   wire access = req.sel && req.enable;
   wire wr = access && req.write && mapped;
   wire rd_csr = access && !req.write && hit_csr;
   wire rd_ist = access && !req.write && hit_ist;
   wire [7:0] csr_byte = {5'h00, csr};
   wire [31:0] rd_mux = hit_csr ? {24'h000000, csr_byte} :
                        hit_pre ? {24'h000000, wake_prescaler_reg} :
                        hit_ist ? {30'h00000000, irq_status} :
                        hit_imk ? {30'h00000000, irq_mask} : 32'h00000000;

   // zero wait states; the read value is latched in the setup phase so a
   // read-clear only drops bits that software actually saw
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   always_ff @(posedge mclk)
   begin
      if (srst)
         prdata <= 32'h00000000;
      else if (setup)
         prdata <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////
   // rc pin sampling: a change counts once stages two and three agree

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rc_s1 <= 1'b0;
         rc_s2 <= 1'b0;
         rc_s3 <= 1'b0;
         rc_lvl <= 1'b0;
         rc_prev <= 1'b0;
      end
      else
      begin
         rc_s1 <= wake_rc_pin;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
         if (rc_s2 == rc_s3)
            rc_lvl <= rc_s3;
         rc_prev <= rc_lvl;
      end
   end
   wire rc_rise = rc_lvl && !rc_prev;

   // strap is caught after reset release, never by the reset itself
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         strap_taken <= 1'b0;
         long_stab <= 1'b0;
      end
      else if (!strap_taken)
      begin
         strap_taken <= 1'b1;
         long_stab <= long_stab_strap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // halt sequencing

   wire in_halt = (state == awu_pkg::ST_RC_START) ||
                  (state == awu_pkg::ST_COUNT) ||
                  (state == awu_pkg::ST_HALT) ||
                  (state == awu_pkg::ST_ACT_HALT);
   wire halt_go = (state == awu_pkg::ST_RUN) && halt_exec;
   wire wdg_trip = halt_go && watchdog_running && watchdog_halt_option &&
                   !osc_irq_enable;
   wire [awu_pkg::CNT_W-1:0] startup_last =
      awu_pkg::CNT_W'(awu_pkg::RC_STARTUP_CYC - 1);
   wire [awu_pkg::CNT_W-1:0] stab_last = long_stab ?
      awu_pkg::CNT_W'(awu_pkg::STAB_LONG - 1) :
      awu_pkg::CNT_W'(awu_pkg::STAB_SHORT - 1);
   wire other_wake = in_halt && halt_exit_irq;
   wire timed_wake = (state == awu_pkg::ST_COUNT) && pre_done;

   always_comb
   begin
      next_state = state;
      case (state)
         awu_pkg::ST_RUN:
            if (halt_exec && !wdg_trip)
            begin
               if (osc_irq_enable)
                  next_state = awu_pkg::ST_ACT_HALT;
               else if (csr.enable)
                  next_state = awu_pkg::ST_RC_START;
               else
                  next_state = awu_pkg::ST_HALT;
            end
         awu_pkg::ST_RC_START:
            if (halt_exit_irq)
               next_state = awu_pkg::ST_STAB;
            else if (cnt == startup_last)
               next_state = awu_pkg::ST_COUNT;
         awu_pkg::ST_COUNT:
            if (halt_exit_irq || pre_done)
               next_state = awu_pkg::ST_STAB;
         awu_pkg::ST_HALT,
         awu_pkg::ST_ACT_HALT:
            if (halt_exit_irq)
               next_state = awu_pkg::ST_STAB;
         awu_pkg::ST_STAB:
            if (cnt == stab_last)
               next_state = awu_pkg::ST_RUN;
         default:
            next_state = awu_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         state <= awu_pkg::ST_RUN;
      else
         state <= next_state;
   end

   // one counter serves rc startup and oscillator stabilisation
   always_ff @(posedge mclk)
   begin
      if (srst || next_state != state)
         cnt <= '0;
      else if (state == awu_pkg::ST_RC_START || state == awu_pkg::ST_STAB)
         cnt <= cnt + awu_pkg::CNT_W'(1);
   end

   awu_prescaler #(
      .DIV(awu_pkg::FIXED_DIV)
   )
   u_prescaler (
      .mclk(mclk),
      .srst(srst),
      .run(state == awu_pkg::ST_COUNT),
      .tick(rc_rise),
      .factor(wake_prescaler_reg),
      .done(pre_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         csr <= awu_pkg::awu_csr_t'(awu_pkg::CSR_RESET);
         wake_prescaler_reg <= awu_pkg::PRE_RESET;
         irq_mask <= awu_pkg::IRQ_RESET;
      end
      else
      begin
         // hardware set wins over the read clear
         csr.flag <= timed_wake ||
                     (csr.flag && !(rd_csr && prdata[awu_pkg::FLAG_BIT]));
         if (wr && hit_csr)
         begin
            csr.measure <= req.wdata[awu_pkg::MEAS_BIT];
            csr.enable <= req.wdata[awu_pkg::EN_BIT];
         end
         if (wr && hit_pre && req.wdata[7:0] != awu_pkg::PRE_FORBIDDEN)
            wake_prescaler_reg <= req.wdata[7:0];
         if (wr && hit_imk)
            irq_mask <= req.wdata[1:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         irq_status <= awu_pkg::IRQ_RESET;
      else
      begin
         irq_status[awu_pkg::EV_TIMED] <= timed_wake ||
            (irq_status[awu_pkg::EV_TIMED] &&
             !(rd_ist && prdata[awu_pkg::EV_TIMED]));
         irq_status[awu_pkg::EV_OTHER] <= other_wake ||
            (irq_status[awu_pkg::EV_OTHER] &&
             !(rd_ist && prdata[awu_pkg::EV_OTHER]));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         watchdog_reset <= 1'b0;
         cc_force <= 1'b0;
      end
      else
      begin
         watchdog_reset <= wdg_trip;
         cc_force <= halt_go && !wdg_trip;
      end
   end

   assign cc_force_value = awu_pkg::CC_HALT_MASK;
   assign core_clk_enable = state == awu_pkg::ST_RUN;
   assign main_osc_enable = state == awu_pkg::ST_RUN ||
                            state == awu_pkg::ST_STAB ||
                            state == awu_pkg::ST_ACT_HALT;
   assign active_halt = state == awu_pkg::ST_ACT_HALT;
   // the cpu only sees the wakeup once the oscillator has settled
   assign timed_wake_irq = csr.flag && core_clk_enable;
   wire measuring = csr.measure && core_clk_enable;
   assign rc_osc_enable = measuring || state == awu_pkg::ST_RC_START ||
                          state == awu_pkg::ST_COUNT;
   assign timer_capture_input_two = measuring && rc_lvl;
   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   sequence s_timed_entry;
      state == awu_pkg::ST_RUN && halt_exec && csr.enable &&
      !osc_irq_enable && !wdg_trip;
   endsequence

   sequence s_stab_done;
      state == awu_pkg::ST_STAB && cnt == stab_last;
   endsequence

   a_timed_entry: assert property (s_timed_entry |=>
      state == awu_pkg::ST_RC_START)
      else $error("timed halt not entered");
   a_rc_running: assert property (state == awu_pkg::ST_COUNT |->
      rc_osc_enable && !main_osc_enable)
      else $error("rc not running in timed halt");
   a_flag_on_done: assert property (timed_wake |=>
      csr.flag && state == awu_pkg::ST_STAB)
      else $error("wake flag not set at delay end");
   a_stab_length: assert property ($rose(state == awu_pkg::ST_STAB) |->
      !core_clk_enable [*8] ##0 main_osc_enable)
      else $error("cpu resumed before stabilisation");
   a_stab_exit: assert property (s_stab_done |=>
      state == awu_pkg::ST_RUN)
      else $error("stabilisation did not end");
   a_read_clears: assert property (rd_csr && prdata[awu_pkg::FLAG_BIT] &&
      !timed_wake |=> !csr.flag && !timed_wake_irq)
      else $error("read did not clear flag");
   a_measure_route: assert property (csr.measure && core_clk_enable |->
      rc_osc_enable && timer_capture_input_two == rc_lvl)
      else $error("measure path wrong");
   a_exit_irq: assert property (other_wake |=>
      state == awu_pkg::ST_STAB)
      else $error("halt exit interrupt ignored");
   a_cc_force: assert property (halt_go && !wdg_trip |=>
      cc_force && cc_force_value == 2'h2)
      else $error("interrupt mask not forced");
   a_halt_stopped: assert property (state == awu_pkg::ST_HALT |->
      !main_osc_enable && !core_clk_enable)
      else $error("clock running in halt");
   a_wdg_reset: assert property (halt_go && watchdog_running &&
      watchdog_halt_option && !osc_irq_enable |=> watchdog_reset &&
      state == awu_pkg::ST_RUN)
      else $error("watchdog reset missing");
   a_zero_ignored: assert property (wr && hit_pre &&
      req.wdata[7:0] == 8'h00 |=> $stable(wake_prescaler_reg))
      else $error("forbidden prescaler accepted");
   a_reserved_zero: assert property (setup && hit_csr |=>
      prdata[7:3] == 5'h00)
      else $error("reserved bits not zero");
   a_active_halt: assert property (halt_go && osc_irq_enable |=>
      active_halt && main_osc_enable)
      else $error("active halt not entered");
   a_pre_stops: assert property (state != awu_pkg::ST_COUNT |=>
      !pre_done)
      else $error("prescaler ran outside halt");
endmodule
`default_nettype wire

// *** dv/awu_rc_model.sv ***
// wakeup rc oscillator model for the timed wakeup bench.
// assumes the bench sets the half period; output idles low when disabled.
`default_nettype none
module awu_rc_model #(
   parameter int HALF_NS = 23
)
(
   // control
   input wire logic en,
   // rc clock
   output logic rc
);
   timeunit 1ns;
   timeprecision 1ns;
   // free running phase, unrelated to mclk, so sync latency varies
   initial
   begin
      rc = 1'b0;
      forever
      begin
         #(HALF_NS);
         rc = en ? ~rc : 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** dv/awu_top_tb_top.sv ***
// self-checking bench for awu_top: apb registers and halt sequences.
// assumes awu_rc_model as the rc oscillator and a 100 MHz mclk.
`default_nettype none
module awu_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RC_HALF = 23;
   localparam int PRE = 2;
   localparam logic [9:0] CSR = awu_pkg::CSR_ADDR;
   localparam logic [9:0] PRS = awu_pkg::PRE_ADDR;
   localparam logic [9:0] IST = awu_pkg::IST_ADDR;
   localparam logic [9:0] IMK = awu_pkg::IMK_ADDR;
   logic mclk = 1'b0, srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, last_err;
   logic halt_exec = 1'b0, osc_irq_enable = 1'b0, halt_exit_irq = 1'b0;
   logic watchdog_running = 1'b0, watchdog_halt_option = 1'b0;
   logic long_stab_strap = 1'b0;
   logic cc_force, core_clk_enable, main_osc_enable, active_halt;
   logic watchdog_reset, timed_wake_irq, wake_rc_pin, rc_osc_enable;
   logic timer_capture_input_two, irq, p;
   logic [1:0] cc_force_value;
   int error_cnt = 0, n_checks = 0, n, k;

   awu_top uut (.mclk(mclk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .halt_exec(halt_exec),
      .osc_irq_enable(osc_irq_enable), .halt_exit_irq(halt_exit_irq),
      .watchdog_running(watchdog_running),
      .watchdog_halt_option(watchdog_halt_option),
      .long_stab_strap(long_stab_strap), .cc_force(cc_force),
      .cc_force_value(cc_force_value),
      .core_clk_enable(core_clk_enable),
      .main_osc_enable(main_osc_enable), .active_halt(active_halt),
      .watchdog_reset(watchdog_reset), .timed_wake_irq(timed_wake_irq),
      .wake_rc_pin(wake_rc_pin), .rc_osc_enable(rc_osc_enable),
      .timer_capture_input_two(timer_capture_input_two), .irq(irq));

   awu_rc_model #(.HALF_NS(RC_HALF)) rc_model (.en(rc_osc_enable),
      .rc(wake_rc_pin));

   initial
   begin
      forever
         #5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic chk_val(input logic [31:0] got, input logic [31:0] e);
      n_checks++;
      if (got !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, got, e);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi)
      begin
         error_cnt++;
         $display("wrong value at %0t: %0d not in %0d..%0d", $time, got,
            lo, hi);
      end
   endtask

   // called right after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic wr, input logic [9:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // no wait limit here: only the watchdog ends a hung transfer
      while (pready !== 1'b1)
         @(posedge mclk);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] x;
      apb(1'b0, a, 32'h0, x);
      chk_val(x, e);
   endtask

   function automatic logic pick(input int s);
      return (s == 0) ? main_osc_enable : core_clk_enable;
   endfunction

   task automatic wait_hi(input int s, input int lim);
      n = 0;
      while (pick(s) !== 1'b1 && n < lim)
      begin
         @(posedge mclk);
         n++;
      end
   endtask

   task automatic halt_go();
      halt_exec <= 1'b1;
      @(posedge mclk);
      halt_exec <= 1'b0;
      @(posedge mclk);
   endtask

   // wake by another interrupt, then run after the stabilisation delay
   task automatic leave(input int stab);
      halt_exit_irq <= 1'b1;
      @(posedge mclk);
      halt_exit_irq <= 1'b0;
      wait_hi(0, 10);
      chk_rng(n, 0, 2);
      chk_val(rc_osc_enable, 32'h0);
      wait_hi(1, 5000);
      chk_rng(n, stab - 6, stab + 2);
      rd(IST, 32'h2);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      #300000;
      error_cnt++;
      end_of_test();
   end

   initial
   begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rd(CSR, 32'h0);
      rd(PRS, 32'hff);
      rd(10'h3fc, 32'h0);
      chk_val(last_err, 1);
      wr(PRS, 32'h0);
      rd(PRS, 32'hff);
      wr(PRS, PRE);
      rd(PRS, PRE);
      wr(CSR, 32'hff);
      rd(CSR, 32'h3);
      k = 0;
      repeat (200)
      begin
         p = timer_capture_input_two;
         @(posedge mclk);
         if (p === 1'b0 && timer_capture_input_two === 1'b1)
            k++;
      end
      chk_rng(k, 30, 50);
      wr(CSR, 32'h1);
      wr(IMK, 32'h1);
      rd(IMK, 32'h1);
      // timed halt cut short by another interrupt mid count
      halt_go();
      chk_val({cc_force, cc_force_value, core_clk_enable,
         main_osc_enable, rc_osc_enable, active_halt}, 7'h62);
      repeat (2100) @(posedge mclk);
      leave(256);
      rd(CSR, 32'h1);
      // full timed halt; count must restart from zero
      halt_go();
      wait_hi(0, 4000);
      chk_rng(n, awu_pkg::RC_STARTUP_CYC - 2 + (64 * PRE - 1) * RC_HALF / 5,
         awu_pkg::RC_STARTUP_CYC + 8 + 64 * PRE * RC_HALF / 5);
      wait_hi(1, 5000);
      chk_rng(n, 254, 258);
      chk_val({timed_wake_irq, irq}, 2'b11);
      rd(IST, 32'h1);
      rd(CSR, 32'h5);
      chk_val({timed_wake_irq, irq}, 2'b00);
      rd(CSR, 32'h1);
      // interrupt already pending at entry
      halt_exit_irq <= 1'b1;
      halt_go();
      halt_exit_irq <= 1'b0;
      wait_hi(0, 5);
      chk_rng(n, 0, 2);
      wait_hi(1, 5000);
      chk_rng(n, 250, 258);
      rd(IST, 32'h2);
      osc_irq_enable <= 1'b1;
      halt_go();
      osc_irq_enable <= 1'b0;
      chk_val({active_halt, main_osc_enable, rc_osc_enable,
         core_clk_enable}, 4'hc);
      leave(256);
      watchdog_running <= 1'b1;
      watchdog_halt_option <= 1'b1;
      halt_go();
      chk_val({watchdog_reset, core_clk_enable}, 2'b11);
      watchdog_halt_option <= 1'b0;
      wr(CSR, 32'h0);
      halt_go();
      chk_val({watchdog_reset, core_clk_enable, rc_osc_enable,
         active_halt, main_osc_enable}, 5'h0);
      leave(256);
      // second reset mid-run, now with the long stabilisation strap
      srst <= 1'b1;
      long_stab_strap <= 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rd(CSR, 32'h0);
      rd(PRS, 32'hff);
      halt_go();
      chk_val({core_clk_enable, main_osc_enable, active_halt}, 3'h0);
      leave(4096);
      end_of_test();
   end
endmodule
`default_nettype wire
